// >>> core_stack_pkg.sv
// Behaviour
// - Two-level return stack holds only instruction pointers; software cannot reach it.
// - Call or interrupt acknowledge pushes instr_pointer; either return pops it back.
// - Reset leaves stack_level_index at zero, so the stack is empty.
// - Full stack latches pending requests but withholds service until a return pops.
// - Call on a full stack drops the oldest entry and keeps two newest.
// - Data memory 20H to 7FH is general purpose; unused locations below read 00H.
// - Location 00H reads and writes the location held in indirect_pointer.
// - Indirect access to 00H itself reads 00H and ignores writes.
// - indirect_pointer keeps seven bits; bit 7 always reads as one.
// - work_reg sits at 05H and is the ALU operand paired with immediates.
// - Eight-bit ALU does arithmetic, decimal adjust, logic, rotates, inc, dec, skips.
// - flag_reg at 0AH: carry, half carry, zero, overflow, sleep, watchdog in bits 0-5.
// - Carry set on add carry or subtract no-borrow; rotates through carry update it.
// - Half carry set on low-nibble carry or no low-nibble borrow, else cleared.
// - Zero flag on zero result, except rotates and decimal adjust; overflow when carry into and out of MSB differ.
// - Writes leave sleep and watchdog flags alone; bits 6 and 7 read zero.
// - Sleep flag cleared by reset or watchdog clear, set by sleep op.
// - Watchdog flag cleared by reset, watchdog clear or sleep; set on timeout.
// - Only instr_pointer is saved on call or interrupt, never flags or work_reg.
// - Servicing clears global_irq_enable; new requests still latch their pending flags.
// - Falling edge on ext_irq_pin_n sets bit 4; serviced calls 04H and clears flags.
// - External and timer requests both wake the core from sleep.
// - Timer overflow sets bit 5; serviced calls 08H and clears flags.
// - isr_exit_op sets global_irq_enable; subroutine_exit_op leaves it alone.
// - Requests sampled once per instruction cycle; external wins over timer.
// - irq_control_reg bits 0-2 are the enables; bits 3, 6, 7 read zero.
`default_nettype none
package core_stack_pkg;
   // ****************************************
   // Sizes and map
   // ****************************************
   localparam int PC_W = 11;
   localparam int STACK_LEVELS = 2;
   localparam int RAM_WORDS = 96;
   localparam logic [6:0] LOC_INDIRECT = 7'h00;
   localparam logic [6:0] LOC_POINTER = 7'h01;
   localparam logic [6:0] LOC_WORK = 7'h05;
   localparam logic [6:0] LOC_FLAGS = 7'h0a;
   localparam logic [6:0] LOC_IRQ = 7'h0b;
   localparam logic [6:0] LOC_RAM_BASE = 7'h20;
   // ****************************************
   // Fields, masks, resets
   // ****************************************
   localparam int F_CARRY = 0;
   localparam int F_HALF = 1;
   localparam int F_ZERO = 2;
   localparam int F_WRAP = 3;
   localparam int F_SLEEP = 4;
   localparam int F_WDOG = 5;
   localparam logic [7:0] FLAG_RD_MASK = 8'h3f;
   localparam logic [7:0] FLAG_WR_MASK = 8'h0f;
   localparam int I_GIE = 0;
   localparam int I_EXT_EN = 1;
   localparam int I_TMR_EN = 2;
   localparam int I_EXT_PEND = 4;
   localparam int I_TMR_PEND = 5;
   localparam logic [7:0] IRQ_MASK = 8'h37;
   localparam logic [7:0] FLAG_RESET = 8'h00;
   localparam logic [7:0] IRQ_RESET = 8'h00;
   localparam logic [6:0] PTR_RESET = 7'h00;
   localparam logic [PC_W-1:0] VEC_EXT = 11'h004;
   localparam logic [PC_W-1:0] VEC_TMR = 11'h008;
   localparam logic [1:0] PHASE_LAST = 2'h3;
   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [3:0] {
      ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_DAA, ALU_AND, ALU_OR, ALU_XOR,
      ALU_CPL, ALU_RL, ALU_RR, ALU_RLC, ALU_RRC, ALU_INC, ALU_DEC
   } alu_op_t;
   typedef struct packed {
      logic valid;
      alu_op_t op;
      logic [7:0] operand;
   } alu_cmd_t;
   typedef struct packed {
      logic call;
      logic ret;
      logic isr_exit_op;
      logic sleep;
      logic wdt_clear;
      logic wdt_timeout;
      logic timer_ovf;
   } core_ops_t;
endpackage
`default_nettype wire

// >>> core_stack_status_interrupt.sv
`default_nettype none
module core_stack_status_interrupt
   import core_stack_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire core_ops_t ops,
   input wire alu_cmd_t alu_cmd,
   input wire logic [PC_W-1:0] pc_in,
   input wire logic ext_irq_pin_n,
   output logic [PC_W-1:0] pc_out,
   output logic pc_load,
   output logic irq_busy,
   output logic skip,
   output logic wake
);
   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic [1:0] phase;
      logic [1:0] level;
      logic [STACK_LEVELS-1:0][PC_W-1:0] stack;
      logic [6:0] ptr;
      logic [7:0] work;
      logic [7:0] flags;
      logic [7:0] irq;
      logic [RAM_WORDS-1:0][7:0] ram;
      logic wr_pend;
      logic wr_ok;
      logic [6:0] wr_loc;
      logic [31:0] hrdata;
      logic ext_prev;
      logic irq_busy;
      logic [PC_W-1:0] vec;
      logic [PC_W-1:0] pc_out;
      logic pc_load;
      logic skip;
      logic wake;
   } st_t;

   st_t s_q;
   st_t s_d;

   initial begin
      if (STACK_LEVELS != 2 || RAM_WORDS != 96) begin
         $error("Stack depth and memory size are fixed by the map");
      end
   end

   // Unimplemented locations, including 00H reached indirectly, read as zero
   function automatic logic [7:0] rd_direct(input st_t s, input logic [6:0] l);
      logic [7:0] v;
      v = 8'h00;
      if (l >= LOC_RAM_BASE) begin
         v = s.ram[l - LOC_RAM_BASE];
      end else begin
         unique case (l)
            LOC_POINTER: v = {1'b1, s.ptr};
            LOC_WORK: v = s.work;
            LOC_FLAGS: v = s.flags & FLAG_RD_MASK;
            LOC_IRQ: v = s.irq & IRQ_MASK;
            default: v = 8'h00;
         endcase
      end
      return v;
   endfunction

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      logic [6:0] loc;
      logic [6:0] eff;
      logic [7:0] a;
      logic [7:0] b;
      logic [8:0] sum;
      logic [4:0] nib;
      logic [7:0] low7;
      logic ci;
      logic [7:0] r;
      logic [8:0] adj;
      logic ack_ext;
      logic ack_tmr;
      s_d = s_q;
      loc = 7'h00;
      eff = 7'h00;
      a = s_q.work;
      b = 8'h00;
      sum = 9'h000;
      nib = 5'h00;
      low7 = 8'h00;
      ci = 1'b0;
      r = 8'h00;
      adj = 9'h000;
      ack_ext = 1'b0;
      ack_tmr = 1'b0;
      s_d.phase = s_q.phase + 2'h1;
      s_d.pc_load = 1'b0;
      s_d.ext_prev = ext_irq_pin_n;

      // Bus write lands in its data phase
      if (s_q.wr_pend && s_q.wr_ok) begin
         eff = (s_q.wr_loc == LOC_INDIRECT) ? s_q.ptr : s_q.wr_loc;
         if (eff >= LOC_RAM_BASE) begin
            s_d.ram[eff - LOC_RAM_BASE] = hwdata[7:0];
         end else begin
            unique case (eff)
               LOC_POINTER: s_d.ptr = hwdata[6:0];
               LOC_WORK: s_d.work = hwdata[7:0];
               LOC_FLAGS: s_d.flags = (s_q.flags & ~FLAG_WR_MASK)
                                      | (hwdata[7:0] & FLAG_WR_MASK);
               LOC_IRQ: s_d.irq = hwdata[7:0] & IRQ_MASK;
               default: s_d.ptr = s_d.ptr;
            endcase
         end
      end

      // ALU works on work_reg and an immediate; only work_reg and flags change
      if (alu_cmd.valid) begin
         b = alu_cmd.operand;
         ci = 1'b0;
         unique case (alu_cmd.op)
            ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC: begin
               // Subtract adds the complement, so carry out means no borrow
               if (alu_cmd.op == ALU_SUB || alu_cmd.op == ALU_SBC) begin
                  b = ~alu_cmd.operand;
               end
               ci = (alu_cmd.op == ALU_ADC || alu_cmd.op == ALU_SBC) ? s_q.flags[F_CARRY]
                    : (alu_cmd.op == ALU_SUB);
               sum = {1'b0, a} + {1'b0, b} + {8'h00, ci};
               nib = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
               low7 = {1'b0, a[6:0]} + {1'b0, b[6:0]} + {7'h00, ci};
               r = sum[7:0];
               s_d.flags[F_CARRY] = sum[8];
               s_d.flags[F_HALF] = nib[4];
               s_d.flags[F_WRAP] = sum[8] ^ low7[7];
            end
            ALU_DAA: begin
               adj = {1'b0, a};
               if (a[3:0] > 4'h9 || s_q.flags[F_HALF]) begin
                  adj = adj + 9'h006;
               end
               if (adj[7:4] > 4'h9 || s_q.flags[F_CARRY] || adj[8]) begin
                  adj = adj + 9'h060;
               end
               r = adj[7:0];
               s_d.flags[F_CARRY] = adj[8] | s_q.flags[F_CARRY];
            end
            ALU_AND: r = a & b;
            ALU_OR: r = a | b;
            ALU_XOR: r = a ^ b;
            ALU_CPL: r = ~a;
            ALU_RL: r = {a[6:0], a[7]};
            ALU_RR: r = {a[0], a[7:1]};
            ALU_RLC: begin
               r = {a[6:0], s_q.flags[F_CARRY]};
               s_d.flags[F_CARRY] = a[7];
            end
            ALU_RRC: begin
               r = {s_q.flags[F_CARRY], a[7:1]};
               s_d.flags[F_CARRY] = a[0];
            end
            ALU_INC: r = a + 8'h01;
            ALU_DEC: r = a - 8'h01;
            default: r = a;
         endcase
         s_d.work = r;
         if (!(alu_cmd.op inside {ALU_RL, ALU_RR, ALU_RLC, ALU_RRC, ALU_DAA})) begin
            s_d.flags[F_ZERO] = (r == 8'h00);
         end
         // Skip decision on a zero result, taken for every ALU operation
         s_d.skip = (r == 8'h00);
      end else begin
         s_d.skip = 1'b0;
      end

      // Power and watchdog flags ignore software and follow events only
      if (ops.sleep) begin
         s_d.flags[F_SLEEP] = 1'b1;
         s_d.flags[F_WDOG] = 1'b0;
      end
      if (ops.wdt_clear) begin
         s_d.flags[F_SLEEP] = 1'b0;
         s_d.flags[F_WDOG] = 1'b0;
      end
      if (ops.wdt_timeout) begin
         s_d.flags[F_WDOG] = 1'b1;
      end

      // Call pushes, and a full stack sheds its oldest entry
      if (ops.call) begin
         if (s_q.level == 2'd2) begin
            s_d.stack[0] = s_q.stack[1];
            s_d.stack[1] = pc_in;
         end else begin
            s_d.stack[s_q.level[0]] = pc_in;
            s_d.level = s_q.level + 2'd1;
         end
      end else if ((ops.ret || ops.isr_exit_op) && s_q.level != 2'd0) begin
         s_d.pc_out = s_q.stack[s_q.level - 2'd1];
         s_d.pc_load = 1'b1;
         s_d.level = s_q.level - 2'd1;
      end
      if (ops.isr_exit_op) begin
         s_d.irq[I_GIE] = 1'b1;
      end

      // Second instruction cycle of an acknowledge loads the vector
      if (s_q.irq_busy && s_q.phase == PHASE_LAST) begin
         s_d.irq_busy = 1'b0;
         s_d.pc_out = s_q.vec;
         s_d.pc_load = 1'b1;
      end

      // Sampling once per instruction cycle; a full stack holds requests off
      if (s_q.phase == PHASE_LAST && !s_q.irq_busy && !ops.call && !ops.ret
          && !ops.isr_exit_op && s_q.irq[I_GIE] && s_q.level != 2'd2) begin
         ack_ext = s_q.irq[I_EXT_PEND] && s_q.irq[I_EXT_EN];
         ack_tmr = !ack_ext && s_q.irq[I_TMR_PEND] && s_q.irq[I_TMR_EN];
      end
      if (ack_ext || ack_tmr) begin
         // Only the instruction pointer is saved; flags and work_reg stay put
         s_d.stack[s_q.level[0]] = pc_in;
         s_d.level = s_q.level + 2'd1;
         s_d.irq[I_GIE] = 1'b0;
         s_d.irq_busy = 1'b1;
         s_d.vec = ack_ext ? VEC_EXT : VEC_TMR;
         if (ack_ext) begin
            s_d.irq[I_EXT_PEND] = 1'b0;
         end else begin
            s_d.irq[I_TMR_PEND] = 1'b0;
         end
      end

      // Requests set last so a same-cycle clear never loses them
      if (s_q.ext_prev && !ext_irq_pin_n) begin
         s_d.irq[I_EXT_PEND] = 1'b1;
      end
      if (ops.timer_ovf) begin
         s_d.irq[I_TMR_PEND] = 1'b1;
      end
      s_d.wake = s_d.flags[F_SLEEP]
                 && ((s_d.irq[I_EXT_PEND] && s_d.irq[I_EXT_EN])
                 || (s_d.irq[I_TMR_PEND] && s_d.irq[I_TMR_EN]));

      // ****************************************
      // Bus address phase
      // ****************************************
      // Read data comes from the updated copy, so a write just before is seen
      s_d.wr_pend = 1'b0;
      if (hsel && htrans[1] && hready) begin
         loc = haddr[8:2];
         s_d.wr_pend = hwrite;
         s_d.wr_loc = loc;
         s_d.wr_ok = (haddr[31:9] == 23'h00_0000);
         if (!hwrite) begin
            s_d.hrdata = 32'h0000_0000;
            if (haddr[31:9] == 23'h00_0000) begin
               s_d.hrdata[7:0] = (loc == LOC_INDIRECT) ? rd_direct(s_d, s_d.ptr)
                                 : rd_direct(s_d, loc);
            end
         end
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q <= '0;
         s_q.level <= 2'd0;
         s_q.ptr <= PTR_RESET;
         s_q.flags <= FLAG_RESET;
         s_q.irq <= IRQ_RESET;
         s_q.ext_prev <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = s_q.hrdata;
   assign pc_out = s_q.pc_out;
   assign pc_load = s_q.pc_load;
   assign irq_busy = s_q.irq_busy;
   assign skip = s_q.skip;
   assign wake = s_q.wake;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_stack_depth_bound: assert property (s_q.level <= 2'd2)
      else $error("Stack index past two levels");
   a_full_call_drop: assert property (ops.call && s_q.level == 2'd2 |=>
      s_q.stack[1] == $past(pc_in) && s_q.stack[0] == $past(s_q.stack[1]))
      else $error("Full stack call kept wrong entries");
   a_return_restores: assert property ((ops.ret || ops.isr_exit_op) && !ops.call
      && s_q.level != 2'd0 |=> pc_load && pc_out == (($past(s_q.level) == 2'd1)
      ? $past(s_q.stack[0]) : $past(s_q.stack[1])))
      else $error("Return did not restore pointer");
   a_full_holds_ack: assert property (s_q.level == 2'd2 |=> !$rose(s_q.irq_busy))
      else $error("Acknowledge with full stack");
   a_ack_gie_clear: assert property ($rose(s_q.irq_busy) |-> !s_q.irq[I_GIE])
      else $error("Global enable left set on acknowledge");
   a_edge_sets_pend: assert property ($fell(ext_irq_pin_n) |=> s_q.irq[I_EXT_PEND])
      else $error("Falling edge not latched");
   a_ext_priority: assert property ($rose(s_q.irq_busy)
      && $past(s_q.irq[I_EXT_PEND]) && $past(s_q.irq[I_EXT_EN]) |-> s_q.vec == VEC_EXT)
      else $error("Timer served before external");
   a_vector_two_cycle: assert property ($rose(s_q.irq_busy) |->
      !pc_load ##4 (pc_load && (pc_out == VEC_EXT || pc_out == VEC_TMR)))
      else $error("Vector not loaded one instruction cycle later");
   a_isr_exit_op_sets_gie: assert property (ops.isr_exit_op |=> s_q.irq[I_GIE])
      else $error("Interrupt return left enable clear");
   a_sleep_flags: assert property (ops.sleep && !ops.wdt_clear && !ops.wdt_timeout
      |=> s_q.flags[F_SLEEP] && !s_q.flags[F_WDOG])
      else $error("Sleep op flags wrong");
   a_wdt_clear_flags: assert property (ops.wdt_clear && !ops.wdt_timeout
      |=> !s_q.flags[F_SLEEP] && !s_q.flags[F_WDOG])
      else $error("Watchdog clear left power flags set");
   a_timeout_sets_flag: assert property (ops.wdt_timeout |=> s_q.flags[F_WDOG])
      else $error("Timeout did not set watchdog flag");

   // Pushes are checked against the slot that the old index selected
   a_call_push_slot: assert property (ops.call && s_q.level == 2'd0
      |=> s_q.stack[0] == $past(pc_in) && s_q.level == 2'd1)
      else $error("Call did not push into the empty stack");
   a_ack_push_pc: assert property ($rose(s_q.irq_busy) && $past(s_q.level) == 2'd1
      |-> s_q.stack[1] == $past(pc_in))
      else $error("Acknowledge pushed the wrong pointer");
   a_ack_needs_gie: assert property ($rose(s_q.irq_busy)
      |-> $past(s_q.irq[I_GIE]) && $past(s_q.level) != 2'd2)
      else $error("Acknowledge without global enable or with full stack");
   a_tmr_sets_pend: assert property (ops.timer_ovf |=> s_q.irq[I_TMR_PEND])
      else $error("Timer overflow not latched");

   // Carry and half carry checks recompute from the operands; the zero check reads the result
   a_zero_flag_logic: assert property (alu_cmd.valid
      && alu_cmd.op inside {ALU_AND, ALU_OR, ALU_XOR}
      |=> s_q.flags[F_ZERO] == (s_q.work == 8'h00))
      else $error("Zero flag wrong after logic op");
   a_rrc_carry_out: assert property (alu_cmd.valid && alu_cmd.op == ALU_RRC
      |=> s_q.flags[F_CARRY] == $past(s_q.work[0]))
      else $error("Rotate through carry lost bit zero");
   a_half_carry_add: assert property (alu_cmd.valid && alu_cmd.op == ALU_ADD
      |=> s_q.flags[F_HALF] == (({1'b0, $past(s_q.work[3:0])}
      + {1'b0, $past(alu_cmd.operand[3:0])}) > 5'h0f))
      else $error("Half carry wrong after add");

   // ****************************************
   // Scenario covers
   // ****************************************
   c_ext_ack: cover property ($rose(s_q.irq_busy) && s_q.vec == VEC_EXT);
   c_held_full: cover property (s_q.level == 2'd2 && s_q.irq[I_TMR_PEND] && s_q.irq[I_GIE]);
   c_indirect_write: cover property (s_q.wr_pend && s_q.wr_loc == LOC_INDIRECT);
   c_tmr_ack: cover property ($rose(s_q.irq_busy) && s_q.vec == VEC_TMR);
   c_full_call: cover property (ops.call && s_q.level == 2'd2);
endmodule
`default_nettype wire

// >>> core_stack_status_interrupt_bench.sv
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin num_errors++; \
   $display("Error at %0t: got %0h expected %0h", $time, a, e); end end
module core_stack_status_interrupt_bench
   import core_stack_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************
   // Signals
   // ****************************************
   localparam core_ops_t OP_CALL = 7'h40;
   localparam core_ops_t OP_RET = 7'h20;
   localparam core_ops_t OP_ISR_EXIT_OP = 7'h10;
   localparam core_ops_t OP_SLEEP = 7'h08;
   localparam core_ops_t OP_WDC = 7'h04;
   localparam core_ops_t OP_TMO = 7'h02;
   localparam core_ops_t OP_TOVF = 7'h01;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, ext_irq_pin_n;
   logic pc_load, irq_busy, skip, wake;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   core_ops_t ops;
   alu_cmd_t alu_cmd;
   logic [PC_W-1:0] pc_in, pc_out, last_pc;
   int num_errors = 0;
   int total_checks = 0;
   int cycles = 0;
   int busy_n;
   logic f;
   // Single slave, so its ready is the bus ready
   assign hready = hreadyout;
   core_stack_status_interrupt uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ops(ops), .alu_cmd(alu_cmd),
      .pc_in(pc_in), .ext_irq_pin_n(ext_irq_pin_n), .pc_out(pc_out), .pc_load(pc_load),
      .irq_busy(irq_busy), .skip(skip), .wake(wake));
   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end
   // Guards against a hang in any wait loop
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 10000) begin
         num_errors++;
         give_verdict();
      end
   end
   // ****************************************
   // Bus and core tasks
   // ****************************************
   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   function automatic logic [31:0] la(input logic [6:0] loc);
      return {23'h00_0000, loc, 2'b00};
   endfunction
   // Entered just after a rising edge; returns at the data-phase edge
   task automatic bus(input logic wr, input logic [31:0] a, input logic [7:0] wd,
      output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= wr;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= {24'h00_0000, wd};
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wr_reg(input logic [6:0] loc, input logic [7:0] d);
      logic [31:0] r;
      bus(1'b1, la(loc), d, r);
   endtask
   task automatic rd_chk(input logic [31:0] a, input logic [7:0] e);
      logic [31:0] r;
      bus(1'b0, a, 8'h00, r);
      `CHK(r, {24'h00_0000, e})
   endtask
   task automatic pulse(input core_ops_t o);
      ops <= o;
      @(posedge hclk);
      ops <= '0;
   endtask
   task automatic call(input logic [PC_W-1:0] pc);
      pc_in <= pc;
      pulse(OP_CALL);
   endtask
   // Bounded wait for the next load, counting busy cycles on the way
   task automatic wait_load(output logic found);
      found = 1'b0;
      busy_n = 0;
      for (int i = 0; i < 20 && !found; i++) begin
         @(posedge hclk);
         if (irq_busy === 1'b1) busy_n++;
         if (pc_load === 1'b1) begin
            found = 1'b1;
            last_pc = pc_out;
         end
      end
   endtask
   task automatic ld_chk(input logic [PC_W-1:0] e);
      wait_load(f);
      `CHK(f, 1'b1)
      `CHK(last_pc, e)
   endtask
   task automatic fall();
      ext_irq_pin_n <= 1'b0;
      repeat (2) @(posedge hclk);
      ext_irq_pin_n <= 1'b1;
      @(posedge hclk);
   endtask
   task automatic alu_case(input alu_op_t op, input logic [7:0] pf, input logic [7:0] a,
      input logic [7:0] b, input logic [7:0] res, input logic chkf, input logic [7:0] fe);
      logic seen;
      wr_reg(LOC_FLAGS, pf);
      wr_reg(LOC_WORK, a);
      alu_cmd <= '{1'b1, op, b};
      @(posedge hclk);
      alu_cmd <= '0;
      seen = 1'b0;
      repeat (3) begin
         @(posedge hclk);
         seen = seen | skip;
      end
      `CHK(seen, (res == 8'h00))
      rd_chk(la(LOC_WORK), res);
      if (chkf) rd_chk(la(LOC_FLAGS), fe);
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_map();
      rd_chk(la(LOC_FLAGS), FLAG_RESET);
      rd_chk(la(LOC_IRQ), IRQ_RESET);
      rd_chk(la(LOC_POINTER), 8'h80);
      rd_chk(la(7'h02), 8'h00);
      rd_chk(32'h0000_0400, 8'h00);
      wr_reg(LOC_POINTER, 8'h20);
      wr_reg(LOC_INDIRECT, 8'h5a);
      rd_chk(la(7'h20), 8'h5a);
      wr_reg(7'h7f, 8'hc3);
      wr_reg(LOC_POINTER, 8'hff);
      rd_chk(la(LOC_POINTER), 8'hff);
      rd_chk(la(LOC_INDIRECT), 8'hc3);
      wr_reg(LOC_POINTER, 8'h80);
      rd_chk(la(LOC_POINTER), 8'h80);
      wr_reg(LOC_INDIRECT, 8'h11);
      rd_chk(la(LOC_INDIRECT), 8'h00);
      rd_chk(la(LOC_POINTER), 8'h80);
      wr_reg(LOC_WORK, 8'h3c);
      rd_chk(la(LOC_WORK), 8'h3c);
      wr_reg(LOC_IRQ, 8'hfe);
      rd_chk(la(LOC_IRQ), 8'h36);
      wr_reg(LOC_IRQ, 8'h00);
      $display("Test map done");
   endtask
   task automatic t_flags();
      wr_reg(LOC_FLAGS, 8'hff);
      rd_chk(la(LOC_FLAGS), 8'h0f);
      pulse(OP_SLEEP);
      pulse(OP_TMO);
      rd_chk(la(LOC_FLAGS), 8'h3f);
      wr_reg(LOC_FLAGS, 8'h00);
      rd_chk(la(LOC_FLAGS), 8'h30);
      pulse(OP_SLEEP);
      rd_chk(la(LOC_FLAGS), 8'h10);
      wr_reg(LOC_IRQ, 8'h06);
      pulse(OP_TOVF);
      repeat (2) @(posedge hclk);
      `CHK(wake, 1'b1)
      wr_reg(LOC_IRQ, 8'h02);
      repeat (2) @(posedge hclk);
      `CHK(wake, 1'b0)
      fall();
      repeat (2) @(posedge hclk);
      `CHK(wake, 1'b1)
      pulse(OP_WDC);
      rd_chk(la(LOC_FLAGS), 8'h00);
      `CHK(wake, 1'b0)
      wr_reg(LOC_IRQ, 8'h00);
      $display("Test flags done");
   endtask
   task automatic t_alu();
      alu_case(ALU_ADD, 8'h00, 8'h7f, 8'h01, 8'h80, 1'b1, 8'h0a);
      alu_case(ALU_ADD, 8'h00, 8'hff, 8'h01, 8'h00, 1'b1, 8'h07);
      alu_case(ALU_SUB, 8'h00, 8'h10, 8'h10, 8'h00, 1'b1, 8'h07);
      alu_case(ALU_SUB, 8'h00, 8'h00, 8'h01, 8'hff, 1'b1, 8'h00);
      alu_case(ALU_ADC, 8'h01, 8'h10, 8'h01, 8'h12, 1'b0, 8'h00);
      alu_case(ALU_SBC, 8'h01, 8'h10, 8'h01, 8'h0f, 1'b0, 8'h00);
      alu_case(ALU_DAA, 8'h00, 8'h0a, 8'h00, 8'h10, 1'b0, 8'h00);
      alu_case(ALU_AND, 8'h00, 8'hf0, 8'h3c, 8'h30, 1'b0, 8'h00);
      alu_case(ALU_OR, 8'h00, 8'h0f, 8'hf0, 8'hff, 1'b0, 8'h00);
      alu_case(ALU_XOR, 8'h00, 8'hff, 8'hff, 8'h00, 1'b0, 8'h00);
      alu_case(ALU_CPL, 8'h00, 8'h0f, 8'h00, 8'hf0, 1'b0, 8'h00);
      alu_case(ALU_RL, 8'h00, 8'h81, 8'h00, 8'h03, 1'b0, 8'h00);
      alu_case(ALU_RR, 8'h00, 8'h81, 8'h00, 8'hc0, 1'b0, 8'h00);
      alu_case(ALU_RLC, 8'h01, 8'h80, 8'h00, 8'h01, 1'b0, 8'h00);
      alu_case(ALU_RRC, 8'h01, 8'h01, 8'h00, 8'h80, 1'b0, 8'h00);
      alu_case(ALU_INC, 8'h00, 8'hff, 8'h00, 8'h00, 1'b0, 8'h00);
      alu_case(ALU_DEC, 8'h00, 8'h01, 8'h00, 8'h00, 1'b0, 8'h00);
      $display("Test alu done");
   endtask
   task automatic t_stack();
      call(11'h123);
      call(11'h234);
      pulse(OP_RET);
      ld_chk(11'h234);
      pulse(OP_RET);
      ld_chk(11'h123);
      pulse(OP_RET);
      wait_load(f);
      `CHK(f, 1'b0)
      call(11'h111);
      call(11'h222);
      call(11'h333);
      pulse(OP_RET);
      ld_chk(11'h333);
      pulse(OP_RET);
      ld_chk(11'h222);
      pulse(OP_RET);
      wait_load(f);
      `CHK(f, 1'b0)
      $display("Test stack done");
   endtask
   task automatic t_full();
      wr_reg(LOC_IRQ, 8'h03);
      call(11'h101);
      call(11'h202);
      pc_in <= 11'h0aa;
      fall();
      wait_load(f);
      `CHK(f, 1'b0)
      rd_chk(la(LOC_IRQ), 8'h13);
      pulse(OP_RET);
      ld_chk(11'h202);
      ld_chk(VEC_EXT);
      `CHK(busy_n, 4)
      fall();
      rd_chk(la(LOC_IRQ), 8'h12);
      pulse(OP_RET);
      ld_chk(11'h0aa);
      rd_chk(la(LOC_IRQ), 8'h12);
      pulse(OP_RET);
      ld_chk(11'h101);
      $display("Test full stack done");
   endtask
   task automatic t_prio();
      wr_reg(LOC_IRQ, 8'h06);
      pulse(OP_TOVF);
      fall();
      rd_chk(la(LOC_IRQ), 8'h36);
      pc_in <= 11'h0bb;
      wr_reg(LOC_IRQ, 8'h37);
      ld_chk(VEC_EXT);
      rd_chk(la(LOC_IRQ), 8'h26);
      pulse(OP_ISR_EXIT_OP);
      ld_chk(11'h0bb);
      ld_chk(VEC_TMR);
      rd_chk(la(LOC_IRQ), 8'h06);
      pulse(OP_ISR_EXIT_OP);
      ld_chk(11'h0bb);
      rd_chk(la(LOC_IRQ), 8'h07);
      $display("Test priority done");
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = '0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = '0;
      ops = '0;
      alu_cmd = '0;
      pc_in = '0;
      ext_irq_pin_n = 1'b1;
      repeat (8) @(posedge hclk);
      `CHK(pc_load, 1'b0)
      `CHK(hreadyout, 1'b1)
      `CHK(hresp, 1'b0)
      hresetn <= 1'b1;
      @(posedge hclk);
      t_map();
      t_flags();
      t_alu();
      t_stack();
      t_full();
      t_prio();
      give_verdict();
   end
endmodule
`default_nettype wire
